//--- sensor_ctrl.sv
// sensor control: led time windows, sample rate limits and die temperature
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctrl_params.svh"
module sensor_ctrl #(
    parameter int CLK_KHZ       = 250000,
    parameter int TEMP_CONV_CYC = 4096
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        link_clk,
    input  wire logic        frame_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [17:0] adc_sample,
    input  wire logic [11:0] temp_sense,
    output logic      [7:0]  red_drive,
    output logic      [7:0]  ir_drive,
    output logic      [15:0] red_current_ua,
    output logic      [15:0] ir_current_ua,
    output logic      [4:0]  adc_bits,
    output logic             fifo_push,
    output logic      [1:0]  fifo_slot,
    output logic      [23:0] fifo_word,
    output logic             temp_ready
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    if (CLK_KHZ < 1000) begin : g_bad_clk
        $error("clock rate too low for the pulse timing");
    end
    if (TEMP_CONV_CYC < 1) begin : g_bad_conv
        $error("conversion time must be at least one cycle");
    end

    sensor_ctrl_pkg::core_state_t s, next_s;
    sensor_reg_if bus ();

    // ************************************************************
    // helpers
    // ************************************************************
    // clock cycles in one led pulse; never below one cycle
    function automatic logic [31:0] pulse_cycles(input logic [1:0] width);
        longint ns;
        longint cyc;
        case (width)
            2'b00:   ns = `PW0_NS;
            2'b01:   ns = `PW1_NS;
            2'b10:   ns = `PW2_NS;
            default: ns = `PW3_NS;
        endcase
        cyc = (ns * longint'(CLK_KHZ)) / `NS_PER_KHZ_DIV;
        if (cyc < 1) cyc = 1;
        return cyc[31:0];
    endfunction : pulse_cycles

    // clock cycles in one sample period
    function automatic logic [31:0] period_cycles(input logic [2:0] rate);
        longint sps;
        longint cyc;
        case (rate)
            3'h0:    sps = `SPS0;
            3'h1:    sps = `SPS1;
            3'h2:    sps = `SPS2;
            3'h3:    sps = `SPS3;
            3'h4:    sps = `SPS4;
            3'h5:    sps = `SPS5;
            3'h6:    sps = `SPS6;
            default: sps = `SPS7;
        endcase
        cyc = (longint'(CLK_KHZ) * `HZ_PER_KHZ) / sps;
        if (cyc < 1) cyc = 1;
        return cyc[31:0];
    endfunction : period_cycles

    // rate code clamped to what the pulse width allows in the given mode
    function automatic sensor_ctrl_pkg::sample_cfg_t clamp_rate(
        input sensor_ctrl_pkg::sample_cfg_t req,
        input logic [2:0] mode
    );
        sensor_ctrl_pkg::sample_cfg_t res;
        logic [2:0] top;
        res = req;
        if (mode == `MODE_HEART) begin
            case (req.width)
                2'b00:   top = `HR_MAX_PW0;
                2'b01:   top = `HR_MAX_PW1;
                2'b10:   top = `HR_MAX_PW2;
                default: top = `HR_MAX_PW3;
            endcase
        end else begin
            // oximetry limits, also applied to multi-led mode
            case (req.width)
                2'b00:   top = `OXI_MAX_PW0;
                2'b01:   top = `OXI_MAX_PW1;
                2'b10:   top = `OXI_MAX_PW2;
                default: top = `OXI_MAX_PW3;
            endcase
        end
        // store the highest allowed rate instead
        if (req.rate > top) res.rate = top;
        return res;
    endfunction : clamp_rate

    // what a time window does in the current mode
    function automatic sensor_ctrl_pkg::slot_use_t slot_use(
        input logic [2:0] mode,
        input logic [1:0] idx,
        input sensor_ctrl_pkg::slot_pair_t lo,
        input sensor_ctrl_pkg::slot_pair_t hi
    );
        sensor_ctrl_pkg::slot_use_t u;
        logic [2:0] sel;
        u = '{active: 1'b0, led: sensor_ctrl_pkg::LED_NONE};
        case (idx)
            2'h0:    sel = lo.lower;
            2'h1:    sel = lo.upper;
            2'h2:    sel = hi.lower;
            default: sel = hi.upper;
        endcase
        case (mode)
            `MODE_HEART: begin
                if (idx == 2'h0) u = '{active: 1'b1, led: sensor_ctrl_pkg::LED_RED};
            end
            `MODE_OXI: begin
                if (idx == 2'h0) u = '{active: 1'b1, led: sensor_ctrl_pkg::LED_RED};
                if (idx == 2'h1) u = '{active: 1'b1, led: sensor_ctrl_pkg::LED_IR};
            end
            `MODE_MULTI: begin
                if (sel == `SEL_RED)     u = '{active: 1'b1, led: sensor_ctrl_pkg::LED_RED};
                else if (sel == `SEL_IR) u = '{active: 1'b1, led: sensor_ctrl_pkg::LED_IR};
                // reserved codes fall through as disabled
                else if (sel != `SEL_OFF && sel <= `SEL_DARK_LAST) u.active = 1'b1;
            end
            default: u.active = 1'b0;
        endcase
        return u;
    endfunction : slot_use

    function automatic logic [15:0] amp_to_ua(input logic [7:0] amp);
        return 16'(amp) * `AMP_STEP_UA;
    endfunction : amp_to_ua

    // ************************************************************
    // serial register port
    // ************************************************************
    sensor_serial_port u_port (
        .clk      (clk),
        .arst_n   (arst_n),
        .link_clk (link_clk),
        .frame_n  (frame_n),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .bus      (bus.port)
    );

    // register read mux; unmapped addresses read as zero
    always_comb begin
        case (bus.addr)
            `REG_MODE:       bus.rdata = {5'h00, s.mode};
            `REG_SAMPLE_CFG: bus.rdata = s.cfg;
            `REG_RED_AMP:    bus.rdata = s.red_amp;
            `REG_IR_AMP:     bus.rdata = s.ir_amp;
            `REG_SLOT_LO:    bus.rdata = s.slots_lo;
            `REG_SLOT_HI:    bus.rdata = s.slots_hi;
            `REG_TEMP_WHOLE: bus.rdata = s.temp_whole;
            `REG_TEMP_PART:  bus.rdata = {4'h0, s.temp_part};
            `REG_TEMP_CTRL:  bus.rdata = {7'h00, s.temp_busy};
            default:         bus.rdata = `RESET_BYTE;
        endcase
    end

    // ************************************************************
    // next state: temperature, register writes, window sequencer
    // ************************************************************
    always_comb begin
        sensor_ctrl_pkg::slot_use_t u;
        sensor_ctrl_pkg::temp_code_t t;
        logic run;
        u = slot_use(s.mode, s.slot_idx, s.slots_lo, s.slots_hi);
        t = temp_sense;
        run = (s.mode == `MODE_HEART) || (s.mode == `MODE_OXI) || (s.mode == `MODE_MULTI);
        next_s            = s;
        next_s.push       = 1'b0;
        next_s.temp_ready = 1'b0;

        // conversion count up to TEMP_CONV_CYC - 1; result split keeps the fraction positive
        if (s.temp_busy) begin
            if (s.temp_cnt >= 32'(TEMP_CONV_CYC - 1)) begin
                next_s.temp_whole = t.whole;
                next_s.temp_part  = t.sixteenths;
                // enable clears itself at the end
                next_s.temp_busy  = 1'b0;
                next_s.temp_ready = 1'b1;
            end else begin
                next_s.temp_cnt = s.temp_cnt + 32'h0000_0001;
            end
        end

        // writes come after the conversion count so a new start wins over the clear
        if (bus.wr_stb) begin
            case (bus.addr)
                `REG_MODE:       next_s.mode = bus.wdata[2:0];
                `REG_SAMPLE_CFG: next_s.cfg = clamp_rate(bus.wdata, s.mode);
                `REG_RED_AMP:    next_s.red_amp = bus.wdata;
                `REG_IR_AMP:     next_s.ir_amp = bus.wdata;
                `REG_SLOT_LO:    next_s.slots_lo = bus.wdata;
                `REG_SLOT_HI:    next_s.slots_hi = bus.wdata;
                `REG_TEMP_CTRL: begin
                    // one conversion per start; a start while busy is ignored, except in the cycle the count finishes
                    if (bus.wdata[0] && (!s.temp_busy || next_s.temp_ready)) begin
                        next_s.temp_busy = 1'b1;
                        next_s.temp_cnt  = 32'h0000_0000;
                    end
                end
                default: ;
            endcase
        end

        // sample period timer; a shortened period wraps at once
        if (!run) begin
            next_s.period_cnt = 32'h0000_0000;
            next_s.seq        = sensor_ctrl_pkg::SEQ_IDLE;
            next_s.red_drive  = 8'h00;
            next_s.ir_drive   = 8'h00;
            next_s.red_ua     = 16'h0000;
            next_s.ir_ua      = 16'h0000;
        end else begin
            if (s.period_cnt >= period_cycles(s.cfg.rate) - 32'h0000_0001) begin
                next_s.period_cnt = 32'h0000_0000;
                // a period starts at the first window only when the sequencer is idle
                if (s.seq == sensor_ctrl_pkg::SEQ_IDLE) begin
                    next_s.seq      = sensor_ctrl_pkg::SEQ_NEXT;
                    next_s.slot_idx = 2'h0;
                end
            end else begin
                next_s.period_cnt = s.period_cnt + 32'h0000_0001;
            end

            case (s.seq)
                sensor_ctrl_pkg::SEQ_NEXT: begin
                    // disabled windows take one cycle and no time slot
                    if (u.active) begin
                        next_s.pulse_cnt = 32'h0000_0000;
                        next_s.seq       = sensor_ctrl_pkg::SEQ_PULSE;
                        if (u.led == sensor_ctrl_pkg::LED_RED) begin
                            next_s.red_drive = s.red_amp;
                            next_s.red_ua    = amp_to_ua(s.red_amp);
                        end
                        if (u.led == sensor_ctrl_pkg::LED_IR) begin
                            next_s.ir_drive = s.ir_amp;
                            next_s.ir_ua    = amp_to_ua(s.ir_amp);
                        end
                    end else if (s.slot_idx == `SLOT_LAST) begin
                        next_s.seq = sensor_ctrl_pkg::SEQ_IDLE;
                    end else begin
                        next_s.slot_idx = s.slot_idx + 2'h1;
                    end
                end
                sensor_ctrl_pkg::SEQ_PULSE: begin
                    if (s.pulse_cnt >= pulse_cycles(s.cfg.width) - 32'h0000_0001) begin
                        next_s.red_drive = 8'h00;
                        next_s.ir_drive  = 8'h00;
                        next_s.red_ua    = 16'h0000;
                        next_s.ir_ua     = 16'h0000;
                        // one three-byte word per active window
                        next_s.push      = 1'b1;
                        next_s.push_slot = s.slot_idx;
                        next_s.push_word = {6'h00, adc_sample};
                        if (s.slot_idx == `SLOT_LAST) begin
                            next_s.seq = sensor_ctrl_pkg::SEQ_IDLE;
                        end else begin
                            next_s.seq      = sensor_ctrl_pkg::SEQ_NEXT;
                            next_s.slot_idx = s.slot_idx + 2'h1;
                        end
                    end else begin
                        next_s.pulse_cnt = s.pulse_cnt + 32'h0000_0001;
                    end
                end
                default: begin
                    next_s.red_drive = 8'h00;
                    next_s.ir_drive  = 8'h00;
                end
            endcase
        end
    end

    // every field, the whole temperature among them, starts at zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) s <= '0;
        else         s <= next_s;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign red_drive      = s.red_drive;
    assign ir_drive       = s.ir_drive;
    assign red_current_ua = s.red_ua;
    assign ir_current_ua  = s.ir_ua;
    // resolution follows the pulse width code
    assign adc_bits       = `RES_BASE + {3'h0, s.cfg.width};
    assign fifo_push      = s.push;
    assign fifo_slot      = s.push_slot;
    assign fifo_word      = s.push_word;
    assign temp_ready     = s.temp_ready;
endmodule : sensor_ctrl
`default_nettype wire

//--- sensor_ctrl_assertions.sv
// port checker for the sensor control block
`timescale 1ns/1ps
`default_nettype none
module sensor_ctrl_assertions (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  red_drive,
    input wire logic [7:0]  ir_drive,
    input wire logic [15:0] red_current_ua,
    input wire logic [15:0] ir_current_ua,
    input wire logic        fifo_push,
    input wire logic        temp_ready
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    // current tracks the code at 200 uA a step
    AST_RED_UA: assert property (red_current_ua == red_drive * 16'h00C8) else $error("red ua");
    AST_IR_UA: assert property (ir_current_ua == ir_drive * 16'h00C8) else $error("ir ua");
    // a window lights one led at most
    AST_ONE_LED: assert property (!(|red_drive && |ir_drive)) else $error("two leds");
    // a window ends with its word pushed, leds dark
    AST_RED_END: assert property ($fell(|red_drive) |-> fifo_push) else $error("red end");
    AST_IR_END: assert property ($fell(|ir_drive) |-> fifo_push) else $error("ir end");
    AST_PUSH_DARK: assert property (fifo_push |-> !(|red_drive) && !(|ir_drive)) else $error("lit");
    AST_PUSH_ONCE: assert property (fifo_push |=> !fifo_push) else $error("push held");
    AST_TRDY_ONCE: assert property (temp_ready |=> !temp_ready [*2]) else $error("ready held");
    cover property (fifo_push);
    cover property (temp_ready);
    cover property (|ir_drive);
endmodule : sensor_ctrl_assertions
bind sensor_ctrl sensor_ctrl_assertions u_sensor_ctrl_assertions (.clk(clk), .arst_n(arst_n),
    .red_drive(red_drive), .ir_drive(ir_drive), .red_current_ua(red_current_ua),
    .ir_current_ua(ir_current_ua), .fifo_push(fifo_push), .temp_ready(temp_ready));
`default_nettype wire

//--- sensor_ctrl_params.svh
// named offsets, reset values, encodings and timing figures of the sensor control block
`ifndef SENSOR_CTRL_PARAMS_SVH
`define SENSOR_CTRL_PARAMS_SVH
// register byte addresses on the serial port
`define REG_MODE        7'h09
`define REG_SAMPLE_CFG  7'h0A
`define REG_RED_AMP     7'h0C
`define REG_IR_AMP      7'h0D
`define REG_SLOT_LO     7'h11
`define REG_SLOT_HI     7'h12
`define REG_TEMP_WHOLE  7'h1F
`define REG_TEMP_PART   7'h20
`define REG_TEMP_CTRL   7'h21
`define RESET_BYTE      8'h00
// operating modes
`define MODE_HEART      3'h2
`define MODE_OXI        3'h3
`define MODE_MULTI      3'h7
// time window selector codes
`define SEL_OFF         3'h0
`define SEL_RED         3'h1
`define SEL_IR          3'h2
`define SEL_DARK_LAST   3'h4
`define SLOT_LAST       2'h3
// drive current per amplitude step, microamps
`define AMP_STEP_UA     16'h00C8
// adc resolution at the narrowest pulse
`define RES_BASE        5'h0F
// pulse widths in nanoseconds
`define PW0_NS          64'h10D56
`define PW1_NS          64'h1CC14
`define PW2_NS          64'h34990
`define PW3_NS          64'h6447E
`define NS_PER_KHZ_DIV  64'hF4240
`define HZ_PER_KHZ      64'h3E8
// samples per second per rate code
`define SPS0            64'h32
`define SPS1            64'h64
`define SPS2            64'hC8
`define SPS3            64'h190
`define SPS4            64'h320
`define SPS5            64'h3E8
`define SPS6            64'h640
`define SPS7            64'hC80
// highest rate code allowed per pulse width
`define OXI_MAX_PW0     3'h6
`define OXI_MAX_PW1     3'h5
`define OXI_MAX_PW2     3'h4
`define OXI_MAX_PW3     3'h3
`define HR_MAX_PW0      3'h7
`define HR_MAX_PW1      3'h6
`define HR_MAX_PW2      3'h6
`define HR_MAX_PW3      3'h5
// serial frame bit positions
`define LINK_HDR_LAST   5'h07
`define LINK_WR_LAST    5'h0F
`define LINK_RD_LOAD    5'h0A
`define LINK_RD_LAST    5'h12
`define LINK_CNT_MAX    5'h1F
`endif

//--- sensor_ctrl_pkg.sv
// types shared by the sensor control block
package sensor_ctrl_pkg;
    typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_NEXT = 2'b01, SEQ_PULSE = 2'b10} seq_state_t;
    typedef enum logic [1:0] {LED_NONE = 2'b00, LED_RED = 2'b01, LED_IR = 2'b10} led_t;
    typedef struct packed {logic rsvd_hi; logic [2:0] upper; logic rsvd_lo; logic [2:0] lower;} slot_pair_t;
    typedef struct packed {logic rsvd; logic [1:0] adc_range; logic [2:0] rate; logic [1:0] width;} sample_cfg_t;
    typedef struct packed {logic [7:0] whole; logic [3:0] sixteenths;} temp_code_t;
    typedef struct packed {logic active; led_t led;} slot_use_t;
    typedef struct packed {
        logic [2:0] mode;
        sample_cfg_t cfg;
        logic [7:0] red_amp;
        logic [7:0] ir_amp;
        slot_pair_t slots_lo;
        slot_pair_t slots_hi;
        logic [7:0] temp_whole;
        logic [3:0] temp_part;
        logic temp_busy;
        logic [31:0] temp_cnt;
        logic temp_ready;
        seq_state_t seq;
        logic [1:0] slot_idx;
        logic [31:0] pulse_cnt;
        logic [31:0] period_cnt;
        logic [7:0] red_drive;
        logic [7:0] ir_drive;
        logic [15:0] red_ua;
        logic [15:0] ir_ua;
        logic push;
        logic [1:0] push_slot;
        logic [23:0] push_word;
    } core_state_t;
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] shift_in;
        logic is_read;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr_tgl;
        logic rd_tgl;
        logic [7:0] shift_out;
        logic drive;
        logic ack_m;
        logic ack_s;
    } link_state_t;
    typedef struct packed {
        logic wr_m;
        logic wr_s;
        logic wr_d;
        logic rd_m;
        logic rd_s;
        logic rd_d;
        logic ack_tgl;
        logic [7:0] rdata_hold;
    } port_state_t;
endpackage : sensor_ctrl_pkg

//--- sensor_host_model.sv
// host serial master; link clock runs inside frames, after one leading edge with frame high
`timescale 1ns/1ps
`default_nettype none
module sensor_host_model (
    output logic     link_clk,
    output logic     frame_n,
    output logic     sda,
    input wire logic sda_line
);
    initial begin
        link_clk = 1'b0;
        frame_n = 1'b1;
        sda = 1'b1;
    end
    // one byte a frame; a leading edge with frame high splits frames
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] w;
        int          n;
        w = {rd, a, d};
        n = rd ? 19 : 16;
        q = 8'h00;
        for (int i = -1; i < n; i++) begin
            frame_n = (i < 0);
            sda = (i < 0 || (rd && i > 7)) ? i[0] : w[15 - i];  // released: toggles
            #62.5 link_clk = 1'b1;
            if (rd && i > 10) q = {q[6:0], sda_line};
            #62.5 link_clk = 1'b0;
        end
        frame_n = 1'b1;
        sda = 1'b1;
        // idle gap so a following frame never starts in this time step
        #62.5;
    endtask : xfer
endmodule : sensor_host_model
`default_nettype wire

//--- sensor_reg_if.sv
// register access strobes between the serial port and the core
`timescale 1ns/1ps
`default_nettype none
interface sensor_reg_if;
    logic       wr_stb;
    logic       rd_stb;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport core (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : sensor_reg_if
`default_nettype wire

//--- sensor_serial_port.sv
// serial register port on the link clock, with crossings into the core clock
`timescale 1ns/1ps
`default_nettype none
`include "sensor_ctrl_params.svh"
module sensor_serial_port (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        link_clk,
    input  wire logic        frame_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    sensor_reg_if.port       bus
);
    sensor_ctrl_pkg::link_state_t l, next_l;
    sensor_ctrl_pkg::port_state_t p, next_p;

    // ************************************************************
    // link side: header, write data, read turnaround and data out
    // ************************************************************
    always_comb begin
        next_l = l;
        next_l.ack_m = p.ack_tgl;
        next_l.ack_s = l.ack_m;
        if (frame_n) begin
            // a clock edge with the frame idle restarts the bit count
            next_l.cnt   = 5'h00;
            next_l.drive = 1'b0;
        end else begin
            if (l.cnt != `LINK_CNT_MAX) next_l.cnt = l.cnt + 5'h01;
            if (l.cnt <= `LINK_HDR_LAST) next_l.shift_in = {l.shift_in[6:0], sda_in};
            if (l.cnt == `LINK_HDR_LAST) begin
                next_l.is_read = l.shift_in[6];
                next_l.addr    = {l.shift_in[5:0], sda_in};
                if (l.shift_in[6]) next_l.rd_tgl = ~l.rd_tgl;
            end
            if (!l.is_read && l.cnt > `LINK_HDR_LAST && l.cnt <= `LINK_WR_LAST) begin
                next_l.wdata = {l.wdata[6:0], sda_in};
                if (l.cnt == `LINK_WR_LAST) next_l.wr_tgl = ~l.wr_tgl;
            end
            if (l.is_read && l.cnt == `LINK_RD_LOAD) begin
                // held word is only trusted once the answer toggle has come back
                next_l.shift_out = (l.ack_s == l.rd_tgl) ? p.rdata_hold : `RESET_BYTE;
                next_l.drive     = 1'b1;
            end else if (l.is_read && l.cnt > `LINK_RD_LOAD && l.cnt < `LINK_RD_LAST) begin
                next_l.shift_out = {l.shift_out[6:0], 1'b0};
            end else if (l.cnt == `LINK_RD_LAST) begin
                next_l.drive = 1'b0;
            end
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) l <= '0;
        else         l <= next_l;
    end

    // the frame signal itself releases the pin, even if the clock has stopped
    assign sda_oe  = l.drive & ~frame_n;
    assign sda_out = l.shift_out[7];

    // ************************************************************
    // core side: toggle synchronisers and read answer
    // ************************************************************
    always_comb begin
        next_p      = p;
        next_p.wr_m = l.wr_tgl;
        next_p.wr_s = p.wr_m;
        next_p.wr_d = p.wr_s;
        next_p.rd_m = l.rd_tgl;
        next_p.rd_s = p.rd_m;
        next_p.rd_d = p.rd_s;
        if (bus.rd_stb) begin
            next_p.rdata_hold = bus.rdata;
            next_p.ack_tgl    = ~p.ack_tgl;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) p <= '0;
        else         p <= next_p;
    end

    // address and data sit still long before the toggle is seen
    assign bus.wr_stb = p.wr_s ^ p.wr_d;
    assign bus.rd_stb = p.rd_s ^ p.rd_d;
    assign bus.addr   = l.addr;
    assign bus.wdata  = l.wdata;
endmodule : sensor_serial_port
`default_nettype wire

//--- tb_sensor_ctrl.sv
// self-checking bench for the sensor control block
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_ctrl;
    logic        clk = 1'b0, arst_n = 1'b0, link_clk, frame_n, host_sda, sda_out, sda_oe;
    logic        fifo_push, temp_ready;
    logic [17:0] adc_sample = 18'h2A5A5;
    logic [11:0] temp_sense = 12'h808;
    logic [7:0]  red_drive, ir_drive, q;
    logic [15:0] red_current_ua, ir_current_ua;
    logic [4:0]  adc_bits;
    logic [1:0]  fifo_slot;
    logic [23:0] fifo_word;
    int          failures = 0, n_checks = 0, n_ready = 0;
    wire         sda_line = sda_oe ? sda_out : host_sda;
    always #2 clk = ~clk;
    always @(posedge clk) if (temp_ready === 1'b1) n_ready <= n_ready + 1;
    sensor_ctrl #(.CLK_KHZ(2000), .TEMP_CONV_CYC(8)) u_sensor_ctrl (.clk(clk), .arst_n(arst_n),
        .link_clk(link_clk), .frame_n(frame_n), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .adc_sample(adc_sample), .temp_sense(temp_sense),
        .red_drive(red_drive), .ir_drive(ir_drive), .red_current_ua(red_current_ua),
        .ir_current_ua(ir_current_ua), .adc_bits(adc_bits), .fifo_push(fifo_push),
        .fifo_slot(fifo_slot), .fifo_word(fifo_word), .temp_ready(temp_ready));
    sensor_host_model u_sensor_host_model (.link_clk(link_clk), .frame_n(frame_n),
        .sda(host_sda), .sda_line(sda_line));
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
    endtask : do_reset
    // write, then give the crossing time to land
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_sensor_host_model.xfer(1'b0, a, d, q);
        repeat (8) @(negedge clk);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string nm);
        u_sensor_host_model.xfer(1'b1, a, 8'h00, q);
        chk(nm, {16'h0000, exp}, {16'h0000, q});
    endtask : rd
    // window order, led choice and word content over four pushes
    task automatic run_mode(input logic [2:0] md, input logic [7:0] exp_seq, input logic [7:0] exp_ir);
        logic [7:0] seq, rmax, imax;
        int         k;
        seq = 8'h00; rmax = 8'h00; imax = 8'h00; k = 0;
        do_reset();
        wr(7'h0C, 8'h05);
        wr(7'h0D, 8'h0A);
        wr(7'h11, 8'h21);  // red then infrared; contiguous from the first window
        wr(7'h12, 8'h53);  // dark third window, reserved fourth
        wr(7'h0A, 8'h18);  // 1600 per second, narrowest pulse
        wr(7'h09, {5'h00, md});
        for (int c = 0; c < 9000 && k < 4; c++) begin
            @(negedge clk);
            if (red_drive > rmax) rmax = red_drive;
            if (ir_drive > imax) imax = ir_drive;
            if (fifo_push === 1'b1) begin
                seq = {seq[5:0], fifo_slot};
                k++;
            end
        end
        if (k < 4) begin
            failures++;
            end_sim();
        end
        chk("window order", {16'h0000, exp_seq}, {16'h0000, seq});
        chk("red amp", 24'h000005, {16'h0000, rmax});
        chk("ir amp", {16'h0000, exp_ir}, {16'h0000, imax});
        chk("fifo word", {6'h00, adc_sample}, fifo_word);
    endtask : run_mode
    task automatic test_temp();
        int base;
        do_reset();
        base = n_ready;
        rd(7'h1F, 8'h00, "whole at reset");
        wr(7'h1F, 8'h55);
        rd(7'h1F, 8'h00, "whole read only");
        wr(7'h21, 8'h01);
        for (int c = 0; c < 200 && n_ready == base; c++) @(negedge clk);
        if (n_ready == base) begin
            failures++;
            end_sim();
        end
        rd(7'h21, 8'h00, "enable cleared");
        rd(7'h1F, 8'h80, "whole");
        rd(7'h20, 8'h08, "sixteenths");
        rd(7'h30, 8'h00, "unmapped");
        chk("ready pulses", 24'h000001, 24'(n_ready - base));
    endtask : test_temp
    // highest allowed rate code per pulse width, widest width in the top field
    task automatic test_rates(input logic [2:0] md, input logic [11:0] tops);
        do_reset();
        wr(7'h09, {5'h00, md});
        for (int w = 3; w >= 0; w--) begin
            wr(7'h0A, {3'h0, 3'h7, w[1:0]});
            rd(7'h0A, {3'h0, tops[3*w +: 3], w[1:0]}, "rate clamp");
            chk("adc bits", 24'(15 + w), {19'h00000, adc_bits});
        end
    endtask : test_rates
    initial begin
        run_mode(3'h7, 8'h18, 8'h0A);
        run_mode(3'h2, 8'h00, 8'h00);
        test_temp();
        test_rates(3'h3, {3'h3, 3'h4, 3'h5, 3'h6});
        test_rates(3'h2, {3'h5, 3'h6, 3'h6, 3'h7});
        end_sim();
    end
endmodule : tb_sensor_ctrl
`default_nettype wire
